// File: verilog/hotswap_defines.svh
`ifndef HOTSWAP_DEFINES_SVH
`define HOTSWAP_DEFINES_SVH

// ***************************************************
// Register offsets (word index on the command port)
// ***************************************************
`define OFS_CONTROL      8'h00
`define OFS_INT_STATUS   8'h01
`define OFS_INT_MASK     8'h02
`define OFS_PAIR_STATE   8'h03
`define OFS_TIMEBASE     8'h04
`define OFS_DELAY_BASE   8'h10
`define OFS_BOUNCE_BASE  8'h20
`define OFS_SOURCE_BASE  8'h30

// ***************************************************
// Control register fields
// ***************************************************
`define CTL_CONNECT_BIT     0
`define CTL_BUSY_BIT        1
`define CTL_DISCONNECT_BIT  2
`define CTL_PLUGGED_BIT     3
`define CTL_LINE_EN_BIT     4

// ***************************************************
// Interrupt status bits
// ***************************************************
`define IRQ_CONNECT_DONE     0
`define IRQ_DISCONNECT_DONE  1

// ***************************************************
// Source select encodings
// ***************************************************
`define SRC_FORCED_OFF   4'h0
`define SRC_FOLLOW       4'h7
`define SRC_FORCED_ON    4'h8

// ***************************************************
// Timing
// ***************************************************
`define CLK_PERIOD_NS      10
`define TICK_NS            1000
`define TICK_CYCLES        (`TICK_NS / `CLK_PERIOD_NS)
`define BOUNCE_HALF_NS     10000
`define BOUNCE_HALF_TICKS  (`BOUNCE_HALF_NS / `TICK_NS)

// ***************************************************
// Reset defaults: steps follow connector pin length
// ***************************************************
`define DEF_DELAY_STEP   16'h0010
`define DEF_SOURCE_P     4'h1
`define DEF_SOURCE_N     4'h2

`endif

// File: verilog/hotswap_pkg.sv
package hotswap_pkg;

   // Sequencer states, gray coded along idle-run-done
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_RUN  = 2'b01,
      SEQ_DONE = 2'b11
   } seq_state_t;

   // Direction of the current sequence
   typedef enum logic {
      DIR_CONNECT    = 1'b0,
      DIR_DISCONNECT = 1'b1
   } seq_dir_t;

   typedef logic [15:0] delay_t;
   typedef logic [3:0]  source_sel_t;

endpackage

// File: verilog/profile_bus_if.sv
`timescale 1ns/10ps

// Shared sequencing context for the timed profiles
interface profile_bus_if;
   import hotswap_pkg::*;

   logic     [15:0] elapsed;       // Ticks since sequence start
   logic     [15:0] span;          // Longest delay plus bounce of the sequence
   logic            tick;          // Common timebase pulse
   logic            running;       // Sequence in progress
   seq_dir_t        dir;           // Connect or disconnect
   logic            clear;         // Sequence start pulse

   modport seq  (output elapsed, span, tick, running, dir, clear);
   modport prof (input  elapsed, span, tick, running, dir, clear);
endinterface

// File: verilog/timed_profile.sv
`timescale 1ns/10ps
`include "hotswap_defines.svh"

// ***************************************************
// One timed source: delay plus optional bounce
// ***************************************************
module timed_profile (
   // Clock and reset
   input  wire logic      core_clk,
   input  wire logic      reset,
   // Shared sequence context
   profile_bus_if.prof    pb,
   // Programmed settings, latched at sequence start
   input  wire logic [15:0] delay_in,
   input  wire logic [7:0]  bounce_in,
   // Profile output, high means connected
   output logic             level
);
   import hotswap_pkg::*;

   logic [15:0] delay_reg, delay_next;    // Frozen delay
   logic [7:0]  bounce_reg, bounce_next;  // Frozen bounce length (ticks)
   logic        level_reg, level_next;    // Output level
   logic [15:0] edge_t;                   // Tick at which the switch moves
   logic [15:0] tail;                     // Ticks past the switch point
   logic        phase;                    // Bounce square wave

   assign level = level_reg;

   // Next state: settings freeze at sequence start so edits take effect later
   always_comb begin
      delay_next  = delay_reg;
      bounce_next = bounce_reg;
      level_next  = level_reg;
      edge_t = (pb.dir == DIR_CONNECT) ? delay_reg : 16'(pb.span - delay_reg);
      tail   = 16'(pb.elapsed - edge_t);
      phase  = tail[0];
      if (pb.clear) begin
         delay_next  = delay_in;
         bounce_next = bounce_in;
      end else if (pb.running) begin
         if (pb.elapsed < edge_t) begin
            level_next = (pb.dir == DIR_DISCONNECT);
         end else if (tail < {8'h00, bounce_reg}) begin
            level_next = (pb.dir == DIR_CONNECT) ? phase : ~phase;
         end else begin
            level_next = (pb.dir == DIR_CONNECT);
         end
      end
   end

   // Register stage
   always_ff @(posedge core_clk) begin
      if (reset) begin
         delay_reg  <= 16'h0000;
         bounce_reg <= 8'h00;
         level_reg  <= 1'b0;
      end else begin
         delay_reg  <= delay_next;
         bounce_reg <= bounce_next;
         level_reg  <= level_next;
      end
   end
endmodule

// File: verilog/cable_pair_hotswap_sequencer.sv
// Behaviour
// - separate switch enable per signal
// - six independent programmable timing profiles
// - profiles hold delay and bounce settings
// - decode select: off, profiles, follow, on
// - nine-way mux, passes when line enabled
// - connect/disconnect commands run all profiles
// - busy bit 1 while sequence runs
// - pair indicator green, orange or off
// - default assignment follows pin lengths
// - disconnect mirrors connect timing
// - changes while plugged apply at disconnect
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "hotswap_defines.svh"

module cable_pair_hotswap_sequencer (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   // Switch enables, order positive then negative per pair
   output logic             pair_one_positive,
   output logic             pair_one_negative,
   output logic             pair_two_positive,
   output logic             pair_two_negative,
   output logic             pair_three_positive,
   output logic             pair_three_negative,
   output logic             pair_four_positive,
   output logic             pair_four_negative,
   // Pair indicators
   output logic      [3:0]  led_green,
   output logic      [3:0]  led_orange,
   // Interrupt
   output logic             irq
);
   import hotswap_pkg::*;

   // ***************************************************
   // State
   // ***************************************************
   profile_bus_if pb ();

   delay_t      delay_reg  [6];          // Per-profile delay (ticks)
   delay_t      delay_next [6];
   logic [7:0]  bounce_reg [6];          // Per-profile bounce length
   logic [7:0]  bounce_next[6];
   source_sel_t source_reg [8];          // Per-signal source select
   source_sel_t source_next[8];
   logic        line_en_reg, line_en_next;     // Hot-swap line enable
   logic        plugged_reg, plugged_next;     // Hot-swap state
   logic [1:0]  irq_stat_reg, irq_stat_next;   // Sticky events
   logic [1:0]  irq_mask_reg, irq_mask_next;   // Event mask
   logic [31:0] rdata_reg, rdata_next;         // Read data
   seq_state_t  state_reg, state_next;         // Sequencer
   seq_dir_t    dir_reg, dir_next;
   logic [15:0] elapsed_reg, elapsed_next;     // Ticks into sequence
   logic [15:0] span_reg, span_next;           // Sequence length
   logic [6:0]  presc_reg, presc_next;         // Timebase prescaler
   logic        clear_reg, clear_next;         // Start pulse to profiles
   logic [7:0]  sw_reg, sw_next;               // Switch enables
   logic [3:0]  green_reg, green_next;
   logic [3:0]  orange_reg, orange_next;
   logic        irq_reg, irq_next;
   logic [5:0]  prof_level;                    // Profile outputs
   logic [15:0] max_delay;                     // Longest profile delay plus bounce
   logic [1:0]  done_evt;                      // Completion events
   logic        busy;

   // ***************************************************
   // Timed profiles
   // ***************************************************
   // six profile instances
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : gen_prof
         timed_profile u_prof (
            .core_clk  (core_clk),
            .reset     (reset),
            .pb        (pb.prof),
            .delay_in  (delay_reg[g]),
            .bounce_in (bounce_reg[g]),
            .level     (prof_level[g])
         );
      end
   endgenerate

   assign pb.elapsed = elapsed_reg;
   assign pb.span    = span_reg;
   assign pb.tick    = (presc_reg == 7'(`TICK_CYCLES - 1));
   assign pb.running = (state_reg == SEQ_RUN);
   assign pb.dir     = dir_reg;
   assign pb.clear   = clear_reg;

   assign busy = (state_reg != SEQ_IDLE) || clear_reg;

   // Longest delay plus bounce sets the sequence length
   always_comb begin
      max_delay = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         if (16'(delay_reg[i] + bounce_reg[i]) > max_delay) begin
            max_delay = 16'(delay_reg[i] + bounce_reg[i]);
         end
      end
   end

   // ***************************************************
   // Sequencer next state
   // ***************************************************
   always_comb begin
      state_next   = state_reg;
      dir_next     = dir_reg;
      elapsed_next = elapsed_reg;
      span_next    = span_reg;
      presc_next   = 7'(presc_reg + 7'h01);
      clear_next   = 1'b0;
      plugged_next = plugged_reg;
      done_evt     = 2'b00;
      if (pb.tick) begin
         presc_next = 7'h00;
      end
      case (state_reg)
         SEQ_IDLE: begin
            if (reg_write && reg_addr == `OFS_CONTROL && !clear_reg) begin
               if (reg_wdata[`CTL_CONNECT_BIT]) begin
                  dir_next   = DIR_CONNECT;
                  clear_next = 1'b1;
               end else if (reg_wdata[`CTL_DISCONNECT_BIT]) begin
                  dir_next   = DIR_DISCONNECT;
                  clear_next = 1'b1;
               end
            end
            if (clear_reg) begin
               state_next   = SEQ_RUN;
               elapsed_next = 16'h0000;
               presc_next   = 7'h00;
               span_next    = max_delay;
               // Follow source moves at once with the command
               plugged_next = (dir_reg == DIR_CONNECT);
            end
         end
         SEQ_RUN: begin
            if (pb.tick) begin
               if (elapsed_reg > span_reg) begin
                  state_next = SEQ_DONE;
               end else begin
                  elapsed_next = 16'(elapsed_reg + 16'h0001);
               end
            end
         end
         SEQ_DONE: begin
            state_next = SEQ_IDLE;
            done_evt   = (dir_reg == DIR_CONNECT) ? 2'b01 : 2'b10;
         end
         default: begin
            state_next = SEQ_IDLE;
         end
      endcase
   end

   // ***************************************************
   // Register file next state
   // ***************************************************
   always_comb begin
      line_en_next  = line_en_reg;
      irq_mask_next = irq_mask_reg;
      delay_next    = delay_reg;
      bounce_next   = bounce_reg;
      source_next   = source_reg;
      rdata_next    = 32'h0000_0000;
      irq_stat_next = irq_stat_reg;
      if (reg_write) begin
         if (reg_addr == `OFS_CONTROL) begin
            line_en_next = reg_wdata[`CTL_LINE_EN_BIT];
         end else if (reg_addr == `OFS_INT_STATUS) begin
            irq_stat_next = irq_stat_reg & ~reg_wdata[1:0];
         end else if (reg_addr == `OFS_INT_MASK) begin
            irq_mask_next = reg_wdata[1:0];
         end
         for (int i = 0; i < 6; i++) begin
            if (reg_addr == 8'(`OFS_DELAY_BASE + i)) begin
               delay_next[i] = reg_wdata[15:0];
            end
            if (reg_addr == 8'(`OFS_BOUNCE_BASE + i)) begin
               bounce_next[i] = reg_wdata[7:0];
            end
         end
         for (int i = 0; i < 8; i++) begin
            if (reg_addr == 8'(`OFS_SOURCE_BASE + i)) begin
               source_next[i] = reg_wdata[3:0];
            end
         end
      end
      // Set wins over a clear in the same cycle
      irq_stat_next = irq_stat_next | done_evt;
      if (reg_read) begin
         case (reg_addr)
            `OFS_CONTROL: begin
               rdata_next[`CTL_BUSY_BIT]    = busy;
               rdata_next[`CTL_PLUGGED_BIT] = plugged_reg;
               rdata_next[`CTL_LINE_EN_BIT] = line_en_reg;
            end
            `OFS_INT_STATUS: rdata_next[1:0] = irq_stat_reg;
            `OFS_INT_MASK:   rdata_next[1:0] = irq_mask_reg;
            `OFS_PAIR_STATE: rdata_next[7:0] = sw_reg;
            `OFS_TIMEBASE:   rdata_next[15:0] = elapsed_reg;
            default: begin
               for (int i = 0; i < 6; i++) begin
                  if (reg_addr == 8'(`OFS_DELAY_BASE + i)) begin
                     rdata_next[15:0] = delay_reg[i];
                  end
                  if (reg_addr == 8'(`OFS_BOUNCE_BASE + i)) begin
                     rdata_next[7:0] = bounce_reg[i];
                  end
               end
               for (int i = 0; i < 8; i++) begin
                  if (reg_addr == 8'(`OFS_SOURCE_BASE + i)) begin
                     rdata_next[3:0] = source_reg[i];
                  end
               end
            end
         endcase
      end
   end

   // ***************************************************
   // Switch mux and indicators
   // ***************************************************
   always_comb begin
      sw_next = sw_reg;
      for (int i = 0; i < 8; i++) begin
         if (line_en_reg) begin
            if (source_reg[i] == `SRC_FORCED_OFF) begin
               sw_next[i] = 1'b0;
            end else if (source_reg[i] == `SRC_FOLLOW) begin
               sw_next[i] = plugged_reg;
            end else if (source_reg[i] == `SRC_FORCED_ON) begin
               sw_next[i] = 1'b1;
            end else if (source_reg[i] <= 4'h6) begin
               sw_next[i] = prof_level[3'(source_reg[i] - 4'h1)];
            end else begin
               // Undefined codes isolate the signal
               sw_next[i] = 1'b0;
            end
         end
      end
      for (int p = 0; p < 4; p++) begin
         green_next[p]  = sw_reg[2*p] & sw_reg[2*p+1];
         orange_next[p] = sw_reg[2*p] ^ sw_reg[2*p+1];
      end
      irq_next = |(irq_stat_reg & irq_mask_reg);
   end

   // ***************************************************
   // Register stage
   // ***************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < 8; i++) begin
            source_reg[i] <= i[0] ? `DEF_SOURCE_N : `DEF_SOURCE_P;
         end
         for (int i = 0; i < 6; i++) begin
            delay_reg[i]  <= 16'(`DEF_DELAY_STEP * (i + 1));
            bounce_reg[i] <= 8'(`BOUNCE_HALF_TICKS);
         end
         line_en_reg  <= 1'b1;
         plugged_reg  <= 1'b0;
         irq_stat_reg <= 2'b00;
         irq_mask_reg <= 2'b00;
         rdata_reg    <= 32'h0000_0000;
         state_reg    <= SEQ_IDLE;
         dir_reg      <= DIR_CONNECT;
         elapsed_reg  <= 16'h0000;
         span_reg     <= 16'h0000;
         presc_reg    <= 7'h00;
         clear_reg    <= 1'b0;
         sw_reg       <= 8'h00;
         green_reg    <= 4'h0;
         orange_reg   <= 4'h0;
         irq_reg      <= 1'b0;
      end else begin
         source_reg   <= source_next;
         delay_reg    <= delay_next;
         bounce_reg   <= bounce_next;
         line_en_reg  <= line_en_next;
         plugged_reg  <= plugged_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         rdata_reg    <= rdata_next;
         state_reg    <= state_next;
         dir_reg      <= dir_next;
         elapsed_reg  <= elapsed_next;
         span_reg     <= span_next;
         presc_reg    <= presc_next;
         clear_reg    <= clear_next;
         sw_reg       <= sw_next;
         green_reg    <= green_next;
         orange_reg   <= orange_next;
         irq_reg      <= irq_next;
      end
   end

   assign pair_one_positive   = sw_reg[0];
   assign pair_one_negative   = sw_reg[1];
   assign pair_two_positive   = sw_reg[2];
   assign pair_two_negative   = sw_reg[3];
   assign pair_three_positive = sw_reg[4];
   assign pair_three_negative = sw_reg[5];
   assign pair_four_positive  = sw_reg[6];
   assign pair_four_negative  = sw_reg[7];
   assign led_green           = green_reg;
   assign led_orange          = orange_reg;
   assign irq                 = irq_reg;
   assign reg_rdata           = rdata_reg;
endmodule

// File: verif/ctrl_model.sv
`timescale 1ns/10ps
// ***************************************************
// Controller side of the command port
// ***************************************************
module ctrl_model (
   // Clock
   input  wire logic        core_clk,
   // Command port
   output logic      [7:0]  reg_addr,
   output logic      [31:0] reg_wdata,
   output logic             reg_write,
   output logic             reg_read,
   input  wire logic [31:0] reg_rdata
);
   // Quiet bus from time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_write = 1'b0;
      reg_read  = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   // Read word stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
endmodule

// File: verif/cable_pair_hotswap_sequencer_assertions.sv
`timescale 1ns/10ps
`include "hotswap_defines.svh"
// ***************************************************
// Port checks of the sequencer
// ***************************************************
module hotswap_checker (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [31:0] reg_rdata,
   // Switches
   input wire logic        pair_one_positive,
   input wire logic        pair_one_negative,
   input wire logic        pair_two_positive,
   input wire logic        pair_two_negative,
   input wire logic        pair_three_positive,
   input wire logic        pair_three_negative,
   input wire logic        pair_four_positive,
   input wire logic        pair_four_negative,
   // Indicators and interrupt
   input wire logic [3:0]  led_green,
   input wire logic [3:0]  led_orange,
   input wire logic        irq
);
   logic [7:0] sw;            // Pair p at bits 2p and 2p+1
   logic       line_en_reg;   // Line enable as last written
   logic       line_en_next;

   assign sw = {pair_four_negative, pair_four_positive, pair_three_negative, pair_three_positive,
                pair_two_negative, pair_two_positive, pair_one_negative, pair_one_positive};

   // Forced sources only pass while the line is enabled
   always_comb begin
      line_en_next = line_en_reg;
      if (reg_write && reg_addr == `OFS_CONTROL)
         line_en_next = reg_wdata[`CTL_LINE_EN_BIT];
   end
   // Enabled out of reset
   always_ff @(posedge core_clk) begin
      line_en_reg <= reset ? 1'b1 : line_en_next;
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   a_reset_quiet: assert property ($past(reset) |-> sw == 8'h00 && !irq
      && led_green == 4'h0 && led_orange == 4'h0) else $error("outputs set after reset");
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   a_busy_read: assert property (
      reg_write && reg_addr == `OFS_CONTROL && reg_wdata[`CTL_CONNECT_BIT] ##2
      reg_read && reg_addr == `OFS_CONTROL |=> reg_rdata[`CTL_BUSY_BIT]) else $error("not busy");
   a_forced_on: assert property (
      reg_write && reg_addr == `OFS_SOURCE_BASE && reg_wdata[3:0] == `SRC_FORCED_ON
      && line_en_reg |-> ##[1:4] pair_one_positive) else $error("forced on not seen");

   // Indicators follow a settled pair
   for (genvar p = 0; p < 4; p++) begin : g_pair
      a_led_excl: assert property ((led_green[p] && led_orange[p]) == 1'b0)
         else $error("green and orange together");
      a_green_full: assert property ((sw[2*p] && sw[2*p+1]) [*3] |-> led_green[p])
         else $error("full pair not green");
      a_orange_part: assert property ((sw[2*p] ^ sw[2*p+1]) [*3] |-> led_orange[p])
         else $error("partial pair not orange");
      a_led_off: assert property ((!sw[2*p] && !sw[2*p+1]) [*3] |-> !led_green[p]
         && !led_orange[p]) else $error("empty pair lit");
   end

   c_connect: cover property (reg_write && reg_addr == `OFS_CONTROL && reg_wdata[0]);
   c_irq: cover property ($rose(irq));
   c_full: cover property (sw == 8'hFE);
endmodule

bind cable_pair_hotswap_sequencer hotswap_checker u_hotswap_checker (.core_clk, .reset,
   .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pair_one_positive,
   .pair_one_negative, .pair_two_positive, .pair_two_negative, .pair_three_positive,
   .pair_three_negative, .pair_four_positive, .pair_four_negative, .led_green,
   .led_orange, .irq);

// File: verif/cable_pair_hotswap_sequencer_tb.sv
`timescale 1ns/10ps
`include "hotswap_defines.svh"
// ***************************************************
// Sequencer bench
// ***************************************************
module cable_pair_hotswap_sequencer_tb;
   logic        core_clk;         // 100 MHz
   logic        reset;            // Sync, high
   logic [7:0]  reg_addr;         // Command port
   logic [31:0] reg_wdata;
   logic        reg_write;
   logic        reg_read;
   logic [31:0] reg_rdata;
   logic [7:0]  sw;               // Pair p at bits 2p and 2p+1
   logic [3:0]  led_green;
   logic [3:0]  led_orange;
   logic        irq;
   logic [31:0] d;                // Last word read
   logic [7:0]  e;                // Expected switches
   int          failures   = 0;
   int          num_checks = 0;
   int          cycles     = 0;   // Hang guard count
   int          t0         = 0;   // Start of the current wait

   cable_pair_hotswap_sequencer u_cable_pair_hotswap_sequencer (
      .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .pair_one_positive(sw[0]), .pair_one_negative(sw[1]),
      .pair_two_positive(sw[2]), .pair_two_negative(sw[3]),
      .pair_three_positive(sw[4]), .pair_three_negative(sw[5]),
      .pair_four_positive(sw[6]), .pair_four_negative(sw[7]),
      .led_green(led_green), .led_orange(led_orange), .irq(irq));
   ctrl_model u_ctrl_model (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Tests need about 5000 cycles; the guard leaves margin
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      u_ctrl_model.rd(a, d);
      check(what, exp, d);
   endtask
   // Wait n cycles past t0, then look between edges
   task automatic wait_to(input int n);
      while (cycles < t0 + n)
         @(posedge core_clk);
      #1;
   endtask
   function automatic logic [3:0] led_of(input logic [7:0] s, input logic all_on);
      for (int p = 0; p < 4; p++)
         led_of[p] = all_on ? &s[2*p +: 2] : ^s[2*p +: 2];
   endfunction
   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      reset = 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      check("switches", 32'h0000_0000, 32'(sw));
      rd_chk(`OFS_CONTROL, 32'h0000_0010, "control");
      rd_chk(`OFS_SOURCE_BASE, 32'(`DEF_SOURCE_P), "source0");
      rd_chk(`OFS_SOURCE_BASE + 8'h01, 32'(`DEF_SOURCE_N), "source1");
      rd_chk(`OFS_DELAY_BASE + 8'h05, 32'h0000_0060, "delay6");
      rd_chk(8'hFF, 32'h0000_0000, "unmapped");
      $display("test defaults finished");
      // Forced sources; a disabled line freezes the switch
      u_ctrl_model.wr(`OFS_SOURCE_BASE, 32'h0000_0008);
      t0 = cycles;
      wait_to(5);
      check("forced on", 32'h0000_0001, 32'(sw[0]));
      u_ctrl_model.wr(`OFS_CONTROL, 32'h0000_0000);
      u_ctrl_model.wr(`OFS_SOURCE_BASE, 32'h0000_0000);
      t0 = cycles;
      wait_to(5);
      check("frozen", 32'h0000_0001, 32'(sw[0]));
      u_ctrl_model.wr(`OFS_CONTROL, 32'h0000_0010);
      t0 = cycles;
      wait_to(5);
      check("forced off", 32'h0000_0000, 32'(sw[0]));
      $display("test sources finished");
      // Profile k waits 2k ticks with no bounce; signal i takes code i
      for (int k = 0; k < 6; k++) begin
         u_ctrl_model.wr(`OFS_DELAY_BASE + 8'(k), 32'(2 * k + 2));
         u_ctrl_model.wr(`OFS_BOUNCE_BASE + 8'(k), 32'h0000_0000);
      end
      for (int i = 0; i < 8; i++)
         u_ctrl_model.wr(`OFS_SOURCE_BASE + 8'(i), 32'(i));
      u_ctrl_model.wr(`OFS_CONTROL, 32'h0000_0011);
      t0 = cycles;
      u_ctrl_model.rd(`OFS_CONTROL, d);
      check("busy", 32'h0000_0002, d & 32'h0000_0002);
      // A pull while busy is dropped
      u_ctrl_model.wr(`OFS_CONTROL, 32'h0000_0014);
      for (int m = 0; m < 7; m++) begin
         wait_to((2 * m + 1) * 100);
         e = 8'h80 | (((8'h01 << (m + 1)) - 8'h01) & 8'h7E);
         check("switches", 32'(e), 32'(sw));
         check("green", 32'(led_of(e, 1'b1)), 32'(led_green));
         check("orange", 32'(led_of(e, 1'b0)), 32'(led_orange));
      end
      wait_to(1500);
      rd_chk(`OFS_CONTROL, 32'h0000_0018, "plugged");
      rd_chk(`OFS_INT_STATUS, 32'h0000_0001, "status");
      check("masked irq", 32'h0000_0000, 32'(irq));
      u_ctrl_model.wr(`OFS_INT_MASK, 32'h0000_0003);
      t0 = cycles;
      wait_to(3);
      check("irq", 32'h0000_0001, 32'(irq));
      u_ctrl_model.wr(`OFS_INT_STATUS, 32'h0000_0001);
      t0 = cycles;
      wait_to(3);
      check("cleared irq", 32'h0000_0000, 32'(irq));
      rd_chk(`OFS_PAIR_STATE, 32'h0000_00FE, "state");
      $display("test connect finished");
      // Profile one moved while plugged; pull mirrors the new timing
      u_ctrl_model.wr(`OFS_DELAY_BASE, 32'h0000_000C);
      u_ctrl_model.wr(`OFS_CONTROL, 32'h0000_0014);
      t0 = cycles;
      for (int m = 0; m < 6; m++) begin
         wait_to((2 * m + 1) * 100);
         e = 8'h00;
         for (int k = 1; k < 7; k++)
            e[k] = (12 - ((k == 1) ? 12 : 2 * k)) > (2 * m + 1);
         check("switches", 32'(e), 32'(sw));
      end
      wait_to(1500);
      rd_chk(`OFS_CONTROL, 32'h0000_0010, "pulled");
      rd_chk(`OFS_INT_STATUS, 32'h0000_0002, "status");
      check("irq", 32'h0000_0001, 32'(irq));
      $display("test disconnect finished");
      // Profile one bounces
      u_ctrl_model.wr(`OFS_BOUNCE_BASE, 32'h0000_0004);
      u_ctrl_model.wr(`OFS_CONTROL, 32'h0000_0011);
      t0 = cycles;
      for (int n = 12; n < 17; n++) begin
         wait_to(n * 100 + 50);
         check("bounce", 32'(n[0] | n == 16), 32'(sw[1]));
      end
      rd_chk(`OFS_TIMEBASE, 32'h0000_0010, "elapsed");
      $display("test bounce finished");
      end_of_test();
   end
endmodule
